// ---- hw/uge_pkg.sv ----
// Purpose: shared constants and types for the usb global control registers
// Assumes: 8-bit special function register bus from the core
// Notes:   offsets are the core's sfr addresses
package uge_pkg;
  localparam logic [7:0] EVT_EN_ADDR  = 8'hBE;
  localparam logic [7:0] FUNC_ADR_ADDR = 8'hC6;
  localparam logic [7:0] EP_SEL_ADDR  = 8'hC7;
  localparam logic [7:0] EVT_EN_RST   = 8'h10;
  localparam logic [7:0] FUNC_ADR_RST = 8'h80;
  localparam logic [7:0] EP_SEL_RST   = 8'h00;
  localparam logic [7:0] EVT_EN_MASK  = 8'h39;
  localparam logic [7:0] EP_SEL_MASK  = 8'h0F;
  localparam int WAKE_BIT    = 5;
  localparam int RST_END_BIT = 4;
  localparam int SOF_BIT     = 3;
  localparam int SUSP_BIT    = 0;
  localparam int FUNC_EN_BIT = 7;
  localparam logic [3:0] EP_LAST = 4'h6;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } uge_sfr_req_t;

  typedef struct packed {
    logic wake;
    logic rst_end;
    logic sof;
    logic susp;
  } uge_evt_t;
endpackage : uge_pkg

// ---- hw/uge_flag.sv ----
// Purpose: one sticky event flag, set by hardware, cleared by software
// Assumes: set and clear are single-cycle pulses on mclk_i
// Notes:   set wins over a clear in the same cycle
`timescale 1ns/1ps
module uge_flag (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule : uge_flag

// ---- hw/uge_regs.sv ----
// Purpose: usb event enable, function address and endpoint select registers
// Assumes: single clock mclk_i, synchronous active-high reset, sfr bus
// Notes:   event flags are kept here to form the usb interrupt and are also output on evt_flags_o
`timescale 1ns/1ps
module uge_regs (
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  input  wire uge_pkg::uge_sfr_req_t sfr_req_i,
  input  wire uge_pkg::uge_evt_t     evt_set_i,
  input  wire uge_pkg::uge_evt_t     evt_clr_i,
  input  wire logic                  bus_reset_i,
  output logic [7:0]                 sfr_rdata_o,
  output logic                       sfr_rvalid_o,
  output uge_pkg::uge_evt_t          evt_flags_o,
  output logic                       usb_irq_o,
  output logic                       function_enable_o,
  output logic [6:0]                 bus_address_field_o,
  output logic [3:0]                 endpoint_index_o
);
  logic [7:0] usb_event_enable_r;
  logic [7:0] usb_function_address_r;
  logic [7:0] endpoint_select_r;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic [3:0] flag_q;
  logic [3:0] en_q;
  logic       wr_en;
  logic       wr_adr;
  logic       wr_ep;
  logic [7:0] rdata_nxt;
  logic       irq_nxt;

  default clocking cb_main @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  assign wr_en  = sfr_req_i.wr && (sfr_req_i.addr == uge_pkg::EVT_EN_ADDR);
  assign wr_adr = sfr_req_i.wr && (sfr_req_i.addr == uge_pkg::FUNC_ADR_ADDR);
  assign wr_ep  = sfr_req_i.wr && (sfr_req_i.addr == uge_pkg::EP_SEL_ADDR);

  // reserved positions are never stored, so they cannot read back as one
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      usb_event_enable_r <= uge_pkg::EVT_EN_RST;
    end else if (wr_en) begin
      usb_event_enable_r <= sfr_req_i.wdata & uge_pkg::EVT_EN_MASK;
    end
  end

  // a bus reset returns to the default address but keeps the enable bit
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      usb_function_address_r <= uge_pkg::FUNC_ADR_RST;
    end else if (bus_reset_i) begin
      usb_function_address_r[6:0] <= 7'h00;
    end else if (wr_adr) begin
      usb_function_address_r <= sfr_req_i.wdata;
    end
  end

  // out-of-range endpoint numbers are stored as written; firmware keeps to 0..6
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      endpoint_select_r <= uge_pkg::EP_SEL_RST;
    end else if (wr_ep) begin
      endpoint_select_r <= sfr_req_i.wdata & uge_pkg::EP_SEL_MASK;
    end
  end

  always_comb begin
    unique case (sfr_req_i.addr)
      uge_pkg::EVT_EN_ADDR:   rdata_nxt = usb_event_enable_r;
      uge_pkg::FUNC_ADR_ADDR: rdata_nxt = usb_function_address_r;
      uge_pkg::EP_SEL_ADDR:   rdata_nxt = endpoint_select_r;
      default:                rdata_nxt = 8'h00;
    endcase
  end

  // registered read data: a read in the cycle of a write sees the old value
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o  <= 8'h00;
      sfr_rvalid_o <= 1'b0;
    end else begin
      sfr_rvalid_o <= sfr_req_i.rd;
      if (sfr_req_i.rd) begin
        sfr_rdata_o <= rdata_nxt;
      end
    end
  end

  assign flag_set = {evt_set_i.wake, evt_set_i.rst_end,
                     evt_set_i.sof, evt_set_i.susp};
  assign flag_clr = {evt_clr_i.wake, evt_clr_i.rst_end,
                     evt_clr_i.sof, evt_clr_i.susp};
  assign en_q = {usb_event_enable_r[uge_pkg::WAKE_BIT],
                 usb_event_enable_r[uge_pkg::RST_END_BIT],
                 usb_event_enable_r[uge_pkg::SOF_BIT],
                 usb_event_enable_r[uge_pkg::SUSP_BIT]};
  assign irq_nxt = |(flag_q & en_q);

  // flags set regardless of enables; enables only mask the request
  for (genvar g = 0; g < 4; g++) begin : g_flag
    uge_flag u_flag (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .set_i     (flag_set[g]),
      .clr_i     (flag_clr[g]),
      .flag_o    (flag_q[g])
    );
  end

  // one cycle of lag on the request keeps every output straight from a flop
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      usb_irq_o   <= 1'b0;
      evt_flags_o <= '0;
    end else begin
      usb_irq_o   <= irq_nxt;
      evt_flags_o <= flag_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      function_enable_o   <= uge_pkg::FUNC_ADR_RST[uge_pkg::FUNC_EN_BIT];
      bus_address_field_o <= uge_pkg::FUNC_ADR_RST[6:0];
      endpoint_index_o    <= uge_pkg::EP_SEL_RST[3:0];
    end else begin
      function_enable_o   <=
        usb_function_address_r[uge_pkg::FUNC_EN_BIT];
      bus_address_field_o <= usb_function_address_r[6:0];
      endpoint_index_o    <= endpoint_select_r[3:0];
    end
  end

  // checks share mclk_i and stay off while sys_rst_i is high
  a_irq_follows: assert property (
    1'b1 |=> (usb_irq_o == $past(irq_nxt)))
    else $error("irq not equal to masked flags");
  a_wake_gate: assert property (
    (flag_q[3] && !en_q[3] && en_q[2:0] == 3'h0) |=> !usb_irq_o)
    else $error("wake irq not masked");
  a_rstend_gate: assert property (
    (flag_q[2] && en_q[2]) |=> usb_irq_o)
    else $error("end of reset irq missing");
  a_sof_gate: assert property (
    (flag_q[1] && en_q[1]) |=> usb_irq_o)
    else $error("sof irq missing");
  a_susp_gate: assert property (
    (flag_q[0] && en_q[0]) |=> usb_irq_o)
    else $error("suspend irq missing");
  a_en_write: assert property (
    wr_en |=> (usb_event_enable_r ==
    ($past(sfr_req_i.wdata) & uge_pkg::EVT_EN_MASK)))
    else $error("enable write not stored");
  a_reserved_zero: assert property (
    ((usb_event_enable_r & ~uge_pkg::EVT_EN_MASK) == 8'h00) &&
    (endpoint_select_r[7:4] == 4'h0))
    else $error("reserved bit set");
  a_rsv_read: assert property (
    (sfr_req_i.rd && sfr_req_i.addr == uge_pkg::EVT_EN_ADDR) |=>
    ((sfr_rdata_o & ~uge_pkg::EVT_EN_MASK) == 8'h00))
    else $error("reserved bit read back as one");
  a_reset_values: assert property (
    $fell(sys_rst_i) |-> (usb_event_enable_r == 8'h10) &&
    (usb_function_address_r == 8'h80) && (endpoint_select_r == 8'h00))
    else $error("wrong reset value");
  a_ep_reset: assert property (
    $fell(sys_rst_i) |-> (endpoint_index_o == uge_pkg::EP_SEL_RST[3:0]))
    else $error("endpoint index not zero after reset");
  a_addr_copy: assert property (
    (wr_adr && !bus_reset_i) |=>
    (usb_function_address_r == $past(sfr_req_i.wdata)))
    else $error("address write not stored");
  a_busrst_addr: assert property (
    bus_reset_i |=> ##1 (bus_address_field_o == 7'h00))
    else $error("address not cleared by bus reset");
  a_busrst_enable: assert property (
    bus_reset_i |=> $stable(usb_function_address_r[uge_pkg::FUNC_EN_BIT]))
    else $error("function enable changed by bus reset");
  a_flag_sets: assert property (
    flag_set[2] |=> flag_q[2])
    else $error("flag not set despite mask");
  a_flag_holds: assert property (
    (flag_q[0] && !flag_clr[0]) |=> flag_q[0])
    else $error("flag cleared without software");
  a_set_wins: assert property (
    (flag_set[1] && flag_clr[1]) |=> flag_q[1])
    else $error("clear beat a same-cycle event");
  a_flag_clears: assert property (
    (flag_clr[3] && !flag_set[3]) |=> !flag_q[3])
    else $error("flag not cleared by software");
  a_ep_write: assert property (
    wr_ep |=> ##1 (endpoint_index_o == $past(sfr_req_i.wdata[3:0], 2)))
    else $error("endpoint index not updated");

  // main scenarios worth seeing in a run
  c_irq_rise: cover property (@(posedge mclk_i) $rose(usb_irq_o));
  c_ep_last: cover property (@(posedge mclk_i)
    wr_ep && sfr_req_i.wdata[3:0] == uge_pkg::EP_LAST);
  c_func_off: cover property (@(posedge mclk_i) $fell(function_enable_o));
  c_busrst: cover property (@(posedge mclk_i) bus_reset_i && wr_adr);
  c_set_clr: cover property (@(posedge mclk_i) flag_set[1] && flag_clr[1]);
endmodule : uge_regs

// ---- dv/uge_core_model.sv ----
// Purpose: core-side sfr master model
// Assumes: requests launched at rising edges
// Notes:   raw writes may set reserved bits, refusal checks only
`timescale 1ns/1ps
module uge_core_model (
  input  wire logic             mclk_i,
  input  wire logic [7:0]       rdata_i,
  input  wire logic             rvalid_i,
  output uge_pkg::uge_sfr_req_t req_o
);
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, d, input bit raw);
    logic [7:0] m;
    m = (a == uge_pkg::EVT_EN_ADDR) ? uge_pkg::EVT_EN_MASK :
        (a == uge_pkg::EP_SEL_ADDR) ? uge_pkg::EP_SEL_MASK : 8'hFF;
    @(posedge mclk_i);
    req_o <= '{1'b1, 1'b0, a, raw ? d : d & m};
    @(posedge mclk_i);
    req_o <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    req_o <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_i);
    req_o <= '0;
    #1;
    // a missing answer poisons the data so the compare fails
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
  endtask : rd
endmodule : uge_core_model

// ---- dv/tb_usb_global_ctrl_regs.sv ----
// Purpose: self-checking bench for the usb control registers
// Assumes: 25 MHz clock, sync reset held 10 cycles
// Notes:   each scenario is its own task
`timescale 1ns/1ps
`define CHK(g, e) chk(8'(g), 8'(e))
module tb_usb_global_ctrl_regs;
  logic                  mclk_i, sys_rst_i, bus_rst, rv, irq, func_en;
  logic [7:0]            rdata, v;
  logic [6:0]            adr;
  logic [3:0]            ep;
  uge_pkg::uge_sfr_req_t req;
  uge_pkg::uge_evt_t     evt_set, evt_clr, flags;
  int                    failures = 0, total_checks = 0;
  int                    eb[4] = '{uge_pkg::SUSP_BIT, uge_pkg::SOF_BIT,
                                   uge_pkg::RST_END_BIT, uge_pkg::WAKE_BIT};
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  uge_regs uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sfr_req_i(req),
    .evt_set_i(evt_set), .evt_clr_i(evt_clr), .bus_reset_i(bus_rst),
    .sfr_rdata_o(rdata), .sfr_rvalid_o(rv), .evt_flags_o(flags),
    .usb_irq_o(irq), .function_enable_o(func_en),
    .bus_address_field_o(adr), .endpoint_index_o(ep));
  uge_core_model core (.mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rv),
    .req_o(req));
  task automatic chk(input logic [7:0] g, e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic settle();
    @(posedge mclk_i);
    #1;
  endtask : settle
  task automatic t_reset();
    core.rd(uge_pkg::EVT_EN_ADDR, v);
    `CHK(v, 8'h10);
    core.rd(uge_pkg::FUNC_ADR_ADDR, v);
    `CHK(v, 8'h80);
    core.rd(uge_pkg::EP_SEL_ADDR, v);
    `CHK(v, 8'h00);
    `CHK(func_en, 1'b1);
    `CHK(adr, 7'h00);
    `CHK(ep, 4'h0);
    core.rd(8'hC5, v);
    `CHK(v, 8'h00);
  endtask : t_reset
  task automatic t_reserved();
    core.wr(uge_pkg::EVT_EN_ADDR, 8'hFF, 1'b1);
    core.rd(uge_pkg::EVT_EN_ADDR, v);
    `CHK(v, 8'h39);
    core.wr(uge_pkg::EP_SEL_ADDR, 8'hFF, 1'b1);
    core.rd(uge_pkg::EP_SEL_ADDR, v);
    `CHK(v, 8'h0F);
    core.wr(uge_pkg::EVT_EN_ADDR, 8'h00, 1'b0);
  endtask : t_reserved
  task automatic t_events();
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      evt_set <= uge_pkg::uge_evt_t'(4'h1 << i);
      @(posedge mclk_i);
      evt_set <= '0;
      settle();
      `CHK(flags, 4'h1 << i);
      `CHK(irq, 1'b0);
      core.wr(uge_pkg::EVT_EN_ADDR, 8'h01 << eb[i], 1'b0);
      settle();
      `CHK(irq, 1'b1);
      `CHK(flags, 4'h1 << i);
      @(posedge mclk_i);
      evt_clr <= uge_pkg::uge_evt_t'(4'h1 << i);
      @(posedge mclk_i);
      evt_clr <= '0;
      settle();
      `CHK(flags, 4'h0);
      `CHK(irq, 1'b0);
      core.wr(uge_pkg::EVT_EN_ADDR, 8'h00, 1'b0);
    end
  endtask : t_events
  task automatic t_address();
    core.wr(uge_pkg::FUNC_ADR_ADDR, 8'h2A, 1'b0);
    settle();
    `CHK(func_en, 1'b0);
    `CHK(adr, 7'h2A);
    @(posedge mclk_i);
    bus_rst <= 1'b1;
    @(posedge mclk_i);
    bus_rst <= 1'b0;
    settle();
    `CHK(adr, 7'h00);
    core.rd(uge_pkg::FUNC_ADR_ADDR, v);
    `CHK(v, 8'h00);
  endtask : t_address
  task automatic t_endpoint();
    for (int n = 0; n <= uge_pkg::EP_LAST; n++) begin
      core.wr(uge_pkg::EP_SEL_ADDR, 8'(n), 1'b0);
      settle();
      `CHK(ep, n);
    end
  endtask : t_endpoint
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    failures++;
    finish_test();
  end
  initial begin
    sys_rst_i = 1'b1;
    bus_rst = 1'b0;
    evt_set = '0;
    evt_clr = '0;
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_reserved();
    t_events();
    t_address();
    t_endpoint();
    finish_test();
  end
endmodule : tb_usb_global_ctrl_regs
